// file: hw/fsp_pkg.sv
package fsp_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_CMD = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam int CTRL_TEMP_UNPROT = 0;
   localparam int CTRL_ALL_PROTECTED = 1;
   localparam int CTRL_ABORT = 2;
   localparam int CTRL_SEL_SECTOR_TOGGLE = 3;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_NEED_RESET = 3;
   localparam int ST_REJECTED = 4;
   localparam int ST_REFUSED = 5;
   localparam int ST_ABORTED = 6;
   localparam int ST_RDATA_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // ****************************************
   // operations started through REG_CMD
   // ****************************************
   localparam logic [3:0] OP_NONE = 4'h0;
   localparam logic [3:0] OP_WRITE = 4'h1;
   localparam logic [3:0] OP_READ = 4'h2;
   localparam logic [3:0] OP_POLL = 4'h3;
   localparam logic [3:0] OP_SECADD = 4'h4;
   localparam logic [3:0] OP_VERIFY = 4'h5;
   localparam logic [3:0] OP_PROTECT = 4'h6;
   localparam logic [3:0] OP_UNPROTECT = 4'h7;
   // ****************************************
   // status bit positions on the flash data bus, and flash address bit positions
   // ****************************************
   localparam int DQ_SECTOR_TOGGLE = 2;
   localparam int DQ_ERASE_TIMER = 3;
   localparam int DQ_TIME_LIMIT = 5;
   localparam int DQ_DEVICE_TOGGLE = 6;
   localparam int ADDR_BIT_ZERO = 0;
   localparam int ADDR_BIT_ONE = 1;
   localparam int ADDR_BIT_SIX = 6;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PS = 5000;
   localparam int T_GLITCH_NS = 5;
   localparam int T_WE_LOW_NS = 35;
   localparam int T_WE_HIGH_NS = 20;
   localparam int T_ACC_NS = 55;
   localparam int T_HV_PULSE_US = 100;
   localparam int WE_LOW_CYC = (T_WE_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int WE_HIGH_CYC = (T_WE_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int GLITCH_CYC = (T_GLITCH_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int SYNC_CYC = 2;
   localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS + SYNC_CYC;
   localparam int HV_PULSE_CYC = (T_HV_PULSE_US * 1000000 + CLK_PS - 1) / CLK_PS;
   // ****************************************
   // sequencer states
   // ****************************************
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_WSET = 6'h02,
      S_WLOW = 6'h04,
      S_WREC = 6'h08,
      S_RACC = 6'h10,
      S_EVAL = 6'h20
   } fsp_st_e;
endpackage : fsp_pkg

// file: hw/fsp_sync.sv
`timescale 1ns/1ps
module fsp_sync #(
   parameter int W = 8
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic [W-1:0] d, // asynchronous input
   output logic [W-1:0] q // synchronised output
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } fsp_sync_s;
   fsp_sync_s st_q, st_d;
   always_comb begin
      st_d = st_q;
      st_d.s2 = st_q.s1;
      st_d.s1 = d;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   // first stage only feeds the second
   genvar i;
   for (i = 0; i < W; i++) begin : g_out
      assign q[i] = st_q.s2[i];
   end
endmodule : fsp_sync

// file: hw/fsp_host.sv
// Notes on behaviour
// R1 - sector toggle bit flips during erase reads
// R2 - device toggle bit flips while busy
// R3 - poll: two reads, equal toggle means finished
// R4 - toggling with time limit set: recheck
// R5 - resumed polling restarts from first read
// R6 - time limit flag set on overrun
// R7 - after overrun only status reads answer
// R8 - reset command before new program or erase
// R9 - no overrun flag for unerased program
// R10 - erase timer flag low during window
// R11 - erase timer high: commands ignored
// R12 - erase timer low: sectors may be added
// R13 - check erase timer before and after add
// R14 - power up in read mode
// R15 - short strobe pulses never start writes
// R16 - write needs chip, write low, output high
// R17 - high voltage reset lifts protection temporarily
// R18 - protect during write pulse with high voltage
// R19 - verify mode: bit zero shows protection
// R20 - identifier read shows protected sector
// R21 - chip unprotect pulse with address bit six
// R22 - unprotected sector reads all zeros
// R23 - protect all sectors before chip unprotect
`timescale 1ns/1ps
module fsp_host #(
   parameter int HV_PULSE_CYC = fsp_pkg::HV_PULSE_CYC,
   parameter logic [7:0] RESET_CMD = 8'hF0,
   parameter logic [7:0] ERASE_CONFIRM_CMD = 8'h30
) (
   input wire logic pclk, // 200 MHz clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   output logic [17:0] flash_addr, // flash address
   output logic [7:0] flash_dq_o, // flash data out
   output logic flash_dq_oe_n, // low while driving data
   input wire logic [7:0] flash_dq_i, // flash data in
   output logic flash_ce_n, // chip enable
   output logic flash_we_n, // write enable
   output logic flash_oe_n, // output enable
   output logic hv_addr_bit_nine, // high voltage on address bit nine
   output logic hv_oe, // high voltage on output enable
   output logic hv_reset // high voltage on reset pin
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      fsp_pkg::fsp_st_e state;
      logic [3:0] op;
      logic [1:0] step;
      logic [23:0] cnt;
      logic tog;
      logic [3:0] ctrl;
      logic [17:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic done, fail, need_reset, rejected, refused, aborted;
      logic [17:0] f_addr;
      logic [7:0] f_dq;
      logic f_dq_oe_n, f_ce_n, f_we_n, f_oe_n, f_hv_a9, f_hv_oe, f_hv_rst;
      logic pready, pslverr;
      logic [31:0] prdata;
   } fsp_host_s;
   fsp_host_s st_q, st_d;
   logic [7:0] dq_s;

   if (HV_PULSE_CYC < 1 || HV_PULSE_CYC > 16777215) begin : g_chk_pulse
      $error("HV_PULSE_CYC out of range");
   end
   if (fsp_pkg::WE_LOW_CYC <= fsp_pkg::GLITCH_CYC) begin : g_chk_glitch
      $error("write pulse not wider than glitch filter");
   end

   fsp_sync #(
      .W(8)
   ) u_dq_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(flash_dq_i),
      .q(dq_s)
   );

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : hit

   function automatic fsp_host_s launch_wr(input fsp_host_s s, input logic [17:0] a,
                                           input logic [7:0] d);
      fsp_host_s r;
      r = s;
      r.f_addr = a;
      r.f_dq = d;
      r.f_dq_oe_n = 1'b0;
      r.f_ce_n = 1'b0;
      r.f_oe_n = 1'b1; // R16
      r.f_we_n = 1'b1;
      r.cnt = 24'(fsp_pkg::WE_HIGH_CYC - 1);
      r.state = fsp_pkg::S_WSET;
      return r;
   endfunction : launch_wr

   function automatic fsp_host_s launch_rd(input fsp_host_s s, input logic [17:0] a);
      fsp_host_s r;
      r = s;
      r.f_addr = a;
      r.f_dq_oe_n = 1'b1;
      r.f_ce_n = 1'b0;
      r.f_oe_n = 1'b0;
      r.f_we_n = 1'b1;
      r.cnt = 24'(fsp_pkg::ACC_CYC - 1);
      r.state = fsp_pkg::S_RACC;
      return r;
   endfunction : launch_rd

   function automatic fsp_host_s finish(input fsp_host_s s);
      fsp_host_s r;
      r = s;
      r.done = 1'b1;
      r.state = fsp_pkg::S_IDLE;
      return r;
   endfunction : finish

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic busy;
      logic cmd_ok;
      logic [3:0] new_op;
      logic tbit;
      logic [17:0] vaddr;
      busy = st_q.state != fsp_pkg::S_IDLE;
      cmd_ok = 1'b0;
      new_op = pwdata[3:0];
      tbit = st_q.ctrl[fsp_pkg::CTRL_SEL_SECTOR_TOGGLE] ?
             st_q.rdata[fsp_pkg::DQ_SECTOR_TOGGLE] : st_q.rdata[fsp_pkg::DQ_DEVICE_TOGGLE]; // R1 R2
      vaddr = st_q.addr;
      vaddr[fsp_pkg::ADDR_BIT_ONE] = 1'b1;
      vaddr[fsp_pkg::ADDR_BIT_ZERO] = 1'b0;
      vaddr[fsp_pkg::ADDR_BIT_SIX] = 1'b0;
      st_d = st_q;
      st_d.f_hv_rst = st_q.ctrl[fsp_pkg::CTRL_TEMP_UNPROT]; // R17

      // apb slave, one wait state; write lands on the ready edge
      st_d.pready = 1'b0;
      st_d.pslverr = 1'b0;
      if (psel && penable && !st_q.pready) begin
         st_d.pready = 1'b1;
         st_d.pslverr = !(hit(paddr, fsp_pkg::REG_CTRL) || hit(paddr, fsp_pkg::REG_ADDR) ||
                          hit(paddr, fsp_pkg::REG_WDATA) || hit(paddr, fsp_pkg::REG_CMD) ||
                          hit(paddr, fsp_pkg::REG_STATUS));
         st_d.prdata = 32'h0000_0000;
         if (hit(paddr, fsp_pkg::REG_CTRL)) st_d.prdata = {28'h0000000, st_q.ctrl};
         if (hit(paddr, fsp_pkg::REG_ADDR)) st_d.prdata = {14'h0000, st_q.addr};
         if (hit(paddr, fsp_pkg::REG_WDATA)) st_d.prdata = {24'h000000, st_q.wdata};
         if (hit(paddr, fsp_pkg::REG_STATUS)) begin
            st_d.prdata = {16'h0000, st_q.rdata, 1'b0, st_q.aborted, st_q.refused,
                           st_q.rejected, st_q.need_reset, st_q.fail, st_q.done, busy};
         end
      end
      if (psel && penable && st_q.pready && pwrite) begin
         if (hit(paddr, fsp_pkg::REG_CTRL)) st_d.ctrl = pwdata[3:0];
         if (hit(paddr, fsp_pkg::REG_ADDR)) st_d.addr = pwdata[17:0];
         if (hit(paddr, fsp_pkg::REG_WDATA)) st_d.wdata = pwdata[7:0];
         if (hit(paddr, fsp_pkg::REG_STATUS)) begin
            // write one to clear; hardware sets below win
            if (pwdata[fsp_pkg::ST_DONE]) st_d.done = 1'b0;
            if (pwdata[fsp_pkg::ST_FAIL]) st_d.fail = 1'b0;
            if (pwdata[fsp_pkg::ST_REJECTED]) st_d.rejected = 1'b0;
            if (pwdata[fsp_pkg::ST_REFUSED]) st_d.refused = 1'b0;
            if (pwdata[fsp_pkg::ST_ABORTED]) st_d.aborted = 1'b0;
         end
         if (hit(paddr, fsp_pkg::REG_CMD)) begin
            cmd_ok = !busy && new_op >= fsp_pkg::OP_WRITE && new_op <= fsp_pkg::OP_UNPROTECT;
            // a failed device takes nothing but the reset command, read and poll
            if (st_q.need_reset && !(new_op == fsp_pkg::OP_WRITE && st_q.wdata == RESET_CMD) &&
                new_op != fsp_pkg::OP_READ && new_op != fsp_pkg::OP_POLL) begin
               cmd_ok = 1'b0; // R8
            end
            if (new_op == fsp_pkg::OP_UNPROTECT && !st_q.ctrl[fsp_pkg::CTRL_ALL_PROTECTED]) begin
               cmd_ok = 1'b0; // R23
            end
            if (!cmd_ok) begin
               st_d.refused = 1'b1;
            end else begin
               st_d.op = new_op;
               st_d.step = 2'd0; // R5
               case (new_op)
                  fsp_pkg::OP_WRITE: begin
                     if (st_q.wdata == RESET_CMD) st_d.need_reset = 1'b0; // R8
                     st_d = launch_wr(st_d, st_q.addr, st_q.wdata);
                  end
                  fsp_pkg::OP_VERIFY: begin
                     st_d.f_hv_a9 = 1'b1; // R19
                     st_d = launch_rd(st_d, vaddr);
                  end
                  fsp_pkg::OP_PROTECT: begin
                     st_d.f_hv_a9 = 1'b1; // R18
                     st_d.f_hv_oe = 1'b1;
                     st_d = launch_wr(st_d, st_q.addr, st_q.wdata);
                     st_d.f_dq_oe_n = 1'b1;
                  end
                  fsp_pkg::OP_UNPROTECT: begin
                     st_d.f_hv_a9 = 1'b1; // R21
                     st_d.f_hv_oe = 1'b1;
                     st_d = launch_wr(st_d, st_q.addr | 18'h00040, st_q.wdata);
                     st_d.f_dq_oe_n = 1'b1;
                  end
                  default: st_d = launch_rd(st_d, st_q.addr);
               endcase
            end
         end
      end

      // ****************************************
      // flash cycle sequencer
      // ****************************************
      case (st_q.state)
         fsp_pkg::S_IDLE: begin
         end
         fsp_pkg::S_WSET: begin
            st_d.cnt = st_q.cnt - 24'd1;
            if (st_q.cnt == 24'd0) begin
               st_d.f_we_n = 1'b0; // R16
               st_d.cnt = (st_q.f_hv_oe) ? 24'(HV_PULSE_CYC - 1) : 24'(fsp_pkg::WE_LOW_CYC - 1);
               st_d.state = fsp_pkg::S_WLOW;
            end
         end
         fsp_pkg::S_WLOW: begin
            // pulse far wider than the glitch filter
            st_d.cnt = st_q.cnt - 24'd1; // R15
            if (st_q.cnt == 24'd0) begin
               st_d.f_we_n = 1'b1; // R18 R21
               st_d.cnt = 24'(fsp_pkg::WE_HIGH_CYC - 1);
               st_d.state = fsp_pkg::S_WREC;
            end
         end
         fsp_pkg::S_WREC: begin
            st_d.cnt = st_q.cnt - 24'd1;
            if (st_q.cnt == 24'd0) begin
               st_d.f_dq_oe_n = 1'b1;
               st_d.f_ce_n = 1'b1;
               st_d.f_hv_a9 = 1'b0;
               st_d.f_hv_oe = 1'b0;
               st_d.state = fsp_pkg::S_EVAL;
            end
         end
         fsp_pkg::S_RACC: begin
            st_d.cnt = st_q.cnt - 24'd1;
            if (st_q.cnt == 24'd0) begin
               st_d.rdata = dq_s;
               st_d.f_ce_n = 1'b1;
               st_d.f_oe_n = 1'b1;
               st_d.f_hv_a9 = 1'b0;
               st_d.state = fsp_pkg::S_EVAL;
            end
         end
         fsp_pkg::S_EVAL: begin
            st_d = finish(st_d);
            if (st_q.op == fsp_pkg::OP_POLL) begin
               st_d.tog = tbit;
               if (st_q.ctrl[fsp_pkg::CTRL_ABORT]) begin
                  st_d.aborted = 1'b1; // R5
               end else if (st_q.step == 2'd0) begin
                  st_d.step = 2'd1; // R3
                  st_d = launch_rd(st_d, st_q.addr);
                  st_d.done = st_q.done;
               end else if (tbit == st_q.tog) begin
                  st_d.fail = 1'b0; // R3
               end else if (st_q.step == 2'd2) begin
                  st_d.fail = 1'b1; // R4
                  st_d.need_reset = 1'b1; // R8
               end else begin
                  if (st_q.rdata[fsp_pkg::DQ_TIME_LIMIT]) st_d.step = 2'd2; // R4
                  st_d = launch_rd(st_d, st_q.addr);
                  st_d.done = st_q.done;
               end
            end else if (st_q.op == fsp_pkg::OP_SECADD) begin
               // a high erase timer on either check marks the add as rejected
               if (st_q.step != 2'd1 && st_q.rdata[fsp_pkg::DQ_ERASE_TIMER]) begin
                  st_d.rejected = 1'b1; // R13
               end else if (st_q.step == 2'd0) begin
                  st_d.step = 2'd1; // R12 R13
                  st_d = launch_wr(st_d, st_q.addr, ERASE_CONFIRM_CMD);
                  st_d.done = st_q.done;
               end else if (st_q.step == 2'd1) begin
                  st_d.step = 2'd2; // R13
                  st_d = launch_rd(st_d, st_q.addr);
                  st_d.done = st_q.done;
               end
            end
         end
         default: st_d.state = fsp_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
         st_q.state <= fsp_pkg::S_IDLE;
         st_q.f_dq_oe_n <= 1'b1;
         st_q.f_ce_n <= 1'b1;
         st_q.f_we_n <= 1'b1;
         st_q.f_oe_n <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata = st_q.prdata;
   assign pready = st_q.pready;
   assign pslverr = st_q.pslverr;
   assign flash_addr = st_q.f_addr;
   assign flash_dq_o = st_q.f_dq;
   assign flash_dq_oe_n = st_q.f_dq_oe_n;
   assign flash_ce_n = st_q.f_ce_n;
   assign flash_we_n = st_q.f_we_n;
   assign flash_oe_n = st_q.f_oe_n;
   assign hv_addr_bit_nine = st_q.f_hv_a9;
   assign hv_oe = st_q.f_hv_oe;
   assign hv_reset = st_q.f_hv_rst;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_write_combo;
      !flash_we_n |-> !flash_ce_n && flash_oe_n;
   endproperty
   a_write_combo: assert property (p_write_combo) else $error("write strobe with bad enables"); // R16

   property p_we_width;
      $fell(flash_we_n) |-> !flash_we_n [*7];
   endproperty
   a_we_width: assert property (p_we_width) else $error("write pulse too short"); // R15

   property p_protect_hv;
      (!flash_we_n && st_q.op == fsp_pkg::OP_PROTECT) |-> hv_addr_bit_nine && hv_oe;
   endproperty
   a_protect_hv: assert property (p_protect_hv) else $error("protect pulse without high voltage"); // R18

   property p_unprot_pins;
      (!flash_we_n && st_q.op == fsp_pkg::OP_UNPROTECT) |->
         flash_addr[6] && hv_addr_bit_nine && hv_oe && !flash_ce_n;
   endproperty
   a_unprot_pins: assert property (p_unprot_pins) else $error("unprotect pins wrong"); // R21

   property p_unprot_gate;
      $fell(flash_we_n) && hv_oe && flash_addr[6] |-> st_q.ctrl[fsp_pkg::CTRL_ALL_PROTECTED];
   endproperty
   a_unprot_gate: assert property (p_unprot_gate) else $error("unprotect without protect all"); // R23

   property p_reset_first;
      $fell(flash_we_n) && (hv_oe || flash_dq_o != RESET_CMD) |-> !st_q.need_reset;
   endproperty
   a_reset_first: assert property (p_reset_first) else $error("write before reset command"); // R8

   property p_verify_addr;
      hv_addr_bit_nine && !flash_oe_n |-> flash_addr[1] && !flash_addr[0] && flash_we_n;
   endproperty
   a_verify_addr: assert property (p_verify_addr) else $error("verify read address wrong"); // R19

   property p_temp_unprot;
      $rose(st_q.ctrl[fsp_pkg::CTRL_TEMP_UNPROT]) |=> hv_reset;
   endproperty
   a_temp_unprot: assert property (p_temp_unprot) else $error("reset high voltage late"); // R17

   property p_dq_contention;
      !flash_dq_oe_n |-> flash_oe_n;
   endproperty
   a_dq_contention: assert property (p_dq_contention) else $error("bus contention on data"); // R16

   property p_poll_two_reads;
      (st_q.state == fsp_pkg::S_EVAL && st_q.op == fsp_pkg::OP_POLL && st_q.step == 2'd0 &&
       !st_q.ctrl[fsp_pkg::CTRL_ABORT]) |=> st_q.state == fsp_pkg::S_RACC && !st_q.done[*2];
   endproperty
   a_poll_two_reads: assert property (p_poll_two_reads) else $error("poll ended after one read"); // R3
endmodule : fsp_host

// file: test/fsp_flash_model.sv
`timescale 1ns/1ps
module fsp_flash_model #(
   parameter logic [7:0] ID_CODE = 8'hA5, // arbitrary value
   parameter logic [7:0] ID_READ_CMD = 8'h90 // identifier read command
) (
   input wire logic [17:0] flash_addr, // address
   input wire logic [7:0] flash_dq_o, // host data
   input wire logic flash_dq_oe_n, // host drives bus
   output logic [7:0] flash_dq_i, // bus level
   input wire logic flash_ce_n, // chip enable
   input wire logic flash_we_n, // write enable
   input wire logic flash_oe_n, // output enable
   input wire logic hv_addr_bit_nine, // hv on a9
   input wire logic hv_oe, // hv on oe
   input wire logic hv_reset, // hv on reset
   input wire logic [7:0] arr, // array byte
   input wire logic [7:0] busy_reads, // toggling reads per program
   input wire logic fail_arm, // next program overruns
   input wire logic erasing, // erase sequence pending
   input wire logic erase_begun, // erase window closed
   output int nwr, // programs taken
   output logic [7:0] last_wd, // last program data
   output int adds // sectors added
);
   // ****************************************
   // status and array read
   // ****************************************
   logic [63:0] prot = '0;
   logic tog = 1'h0;
   logic failed = 1'h0;
   logic id_mode = 1'h0;
   logic rd_act;
   logic [7:0] cnt = 8'h00;
   logic [7:0] rv;
   logic [7:0] last = 8'h00;
   realtime t_fall = 0;
   initial begin
      nwr = 0;
      adds = 0;
      last_wd = 8'h00;
   end
   always_comb begin
      if (hv_addr_bit_nine || id_mode) begin
         rv = flash_addr[1] ? {7'h00, prot[flash_addr[17:12]]} : ID_CODE;
      end
      else if (cnt != 8'h00 || failed || erasing) rv = {1'h0, tog, failed, 1'h0, erase_begun, tog, 2'h0};
      else rv = arr;
   end
   // released bus shows the inverse of its last value
   assign flash_dq_i = !flash_dq_oe_n ? flash_dq_o : (!flash_ce_n && !flash_oe_n) ? rv : ~last;
   assign rd_act = !flash_ce_n && !flash_oe_n;
   // read ends when either enable rises; host lifts both at once
   always @(negedge rd_act) begin
      last = rv;
      if (cnt != 8'h00 || failed || erasing) tog = ~tog;
      if (cnt != 8'h00) cnt = cnt - 8'h01;
   end
   // ****************************************
   // write cycles
   // ****************************************
   always @(negedge flash_we_n) t_fall = $realtime;
   always @(posedge flash_we_n) begin
      if (!flash_ce_n && (flash_oe_n || hv_oe) && $realtime - t_fall >= 5.0) begin
         if (hv_addr_bit_nine && hv_oe) begin
            if (flash_addr[6]) prot = '0;
            else prot[flash_addr[17:12]] = 1'h1;
         end else if (flash_dq_o == 8'hF0) begin
            failed = 1'h0;
            id_mode = 1'h0;
         end else if (!failed && flash_dq_o == ID_READ_CMD) id_mode = 1'h1;
         else if (!failed && flash_dq_o == 8'h30) begin
            if (!erase_begun) adds++;
         end else if (!failed && (!prot[flash_addr[17:12]] || hv_reset)) begin
            nwr++;
            last_wd = flash_dq_o;
            cnt = busy_reads;
            failed = fail_arm;
         end
      end
   end
endmodule : fsp_flash_model

// file: test/fsp_host_tb.sv
`timescale 1ns/1ps
module fsp_host_tb;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00, arr = 8'h00, busy_reads = 8'h00, last_wd, d;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, fail_arm = 1'h0, erasing = 1'h0, erase_begun = 1'h0;
   logic [17:0] flash_addr;
   logic [7:0] dq_o, dq_i;
   logic dq_oe_n, ce_n, we_n, oe_n, hv9, hvoe, hvrst;
   int miscompares = 0, checks_done = 0, nwr, adds;
   logic [7:0] wq[$];
   fsp_host #(.HV_PULSE_CYC(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_o(dq_o),
      .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_i), .flash_ce_n(ce_n), .flash_we_n(we_n),
      .flash_oe_n(oe_n), .hv_addr_bit_nine(hv9), .hv_oe(hvoe), .hv_reset(hvrst));
   fsp_flash_model flash (.flash_addr(flash_addr), .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n),
      .flash_dq_i(dq_i), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
      .hv_addr_bit_nine(hv9), .hv_oe(hvoe), .hv_reset(hvrst), .arr(arr), .busy_reads(busy_reads),
      .fail_arm(fail_arm), .erasing(erasing), .erase_begun(erase_begun), .nwr(nwr),
      .last_wd(last_wd), .adds(adds));
   // ****************************************
   // bus tasks
   // ****************************************
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dd);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dd;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb
   // abort during the wait is optional; status is left in rd
   task automatic op(input logic [3:0] c, input logic [17:0] a, input logic [7:0] dd,
                     input logic ab);
      int n;
      apb(1'h1, fsp_pkg::REG_STATUS, 32'h0000_007F);
      apb(1'h1, fsp_pkg::REG_ADDR, {14'h0, a});
      apb(1'h1, fsp_pkg::REG_WDATA, {24'h0, dd});
      apb(1'h1, fsp_pkg::REG_CMD, {28'h0, c});
      if (ab) apb(1'h1, fsp_pkg::REG_CTRL, 32'h0000_0004);
      n = 0;
      do begin
         apb(1'h0, fsp_pkg::REG_STATUS, 32'h0);
         n++;
      end while (rd[fsp_pkg::ST_BUSY] !== 1'h0 && n < 600);
   endtask : op
   task automatic results;
      if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   // ****************************************
   // scenarios
   // ****************************************
   initial forever #2.5 pclk = ~pclk;
   initial begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      results();
   end
   initial begin
      rd = $urandom(54371);
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      chk("idle pins", {29'h0, ce_n, we_n, dq_oe_n}, 32'h7);
      apb(1'h0, fsp_pkg::REG_CTRL, 32'h0);
      chk("ctrl", rd, fsp_pkg::CTRL_RESET);
      apb(1'h0, 8'h40, 32'h0);
      chk("slverr", {31'h0, err}, 32'h1);
      arr <= 8'($urandom);
      op(fsp_pkg::OP_READ, 18'($urandom), 8'h00, 1'h0);
      chk("read", {24'h0, rd[15:8]}, {24'h0, arr});
      for (int i = 0; i < 6; i++) begin
         d = 8'($urandom) | 8'h01;
         busy_reads <= 8'($urandom_range(5, 1));
         apb(1'h1, fsp_pkg::REG_CTRL, {28'h0, i[0], 3'h0});
         op(fsp_pkg::OP_WRITE, {6'h00, 12'($urandom)}, d, 1'h0);
         wq.push_back(d);
         chk("wr st", rd & 32'h3F, 32'h02);
         op(fsp_pkg::OP_POLL, 18'h0, 8'h00, 1'h0);
         chk("poll st", rd & 32'h3F, 32'h02);
         chk("wdata", {24'h0, last_wd}, {24'h0, wq[$]});
      end
      busy_reads <= 8'h60;
      op(fsp_pkg::OP_WRITE, 18'h0, 8'h43, 1'h0);
      wq.push_back(8'h43);
      op(fsp_pkg::OP_POLL, 18'h0, 8'h00, 1'h1);
      chk("abort", rd & 32'h45, 32'h40);
      apb(1'h1, fsp_pkg::REG_CTRL, 32'h0);
      op(fsp_pkg::OP_POLL, 18'h0, 8'h00, 1'h0);
      chk("repoll", rd & 32'h07, 32'h02);
      fail_arm <= 1'h1;
      op(fsp_pkg::OP_WRITE, 18'h0, 8'h55, 1'h0);
      wq.push_back(8'h55);
      fail_arm <= 1'h0;
      op(fsp_pkg::OP_POLL, 18'h0, 8'h00, 1'h0);
      chk("overrun", rd & 32'h0C, 32'h0C);
      op(fsp_pkg::OP_WRITE, 18'h0, 8'h11, 1'h0);
      chk("refused", rd & 32'h21, 32'h20);
      op(fsp_pkg::OP_WRITE, 18'h0, 8'hF0, 1'h0);
      chk("reset cmd", rd & 32'h0C, 32'h0);
      erasing <= 1'h1;
      for (int i = 0; i < 2; i++) begin
         erase_begun <= i[0];
         op(fsp_pkg::OP_SECADD, 18'h0, 8'h00, 1'h0);
         chk("secadd", rd & 32'h12, {27'h0, i[0], 4'h2});
         chk("adds", 32'(adds), 32'h1);
      end
      erasing <= 1'h0;
      erase_begun <= 1'h0;
      op(fsp_pkg::OP_PROTECT, 18'h05000, 8'h00, 1'h0);
      op(fsp_pkg::OP_VERIFY, 18'h05000, 8'h00, 1'h0);
      chk("prot", {24'h0, rd[15:8]}, 32'h01);
      op(fsp_pkg::OP_VERIFY, 18'h06000, 8'h00, 1'h0);
      chk("unprot", {24'h0, rd[15:8]}, 32'h00);
      op(fsp_pkg::OP_WRITE, 18'h0, 8'h90, 1'h0);
      op(fsp_pkg::OP_READ, 18'h05002, 8'h00, 1'h0);
      chk("id read", {24'h0, rd[15:8]}, 32'h01);
      op(fsp_pkg::OP_WRITE, 18'h0, 8'hF0, 1'h0);
      op(fsp_pkg::OP_WRITE, 18'h05010, 8'h21, 1'h0);
      apb(1'h1, fsp_pkg::REG_CTRL, 32'h1);
      @(posedge pclk);
      chk("hv_reset", {31'h0, hvrst}, 32'h1);
      op(fsp_pkg::OP_WRITE, 18'h05010, 8'h23, 1'h0);
      wq.push_back(8'h23);
      chk("nwr", 32'(nwr), 32'(wq.size()));
      apb(1'h1, fsp_pkg::REG_CTRL, 32'h0);
      op(fsp_pkg::OP_UNPROTECT, 18'h0, 8'h00, 1'h0);
      chk("guard", rd & 32'h20, 32'h20);
      apb(1'h1, fsp_pkg::REG_CTRL, 32'h2);
      op(fsp_pkg::OP_UNPROTECT, 18'h0, 8'h00, 1'h0);
      op(fsp_pkg::OP_VERIFY, 18'h05000, 8'h00, 1'h0);
      chk("chip unprot", {24'h0, rd[15:8]}, 32'h00);
      results();
   end
endmodule : fsp_host_tb
